/* File: pot_defs.svh */
// Purpose: constants for the serial target port of the programmable potentiometer
// Assumes: included by its bare name from the sampler, wiper store and target files
// Notes: offsets, field positions, reset values and counts live here as macros
//
// What this block does
// - Read sends wiper byte right after address ack
// - Nine clocks per byte, MSB first, ack
// - Data changes only while serial clock low
// - Read then sends status byte, top two bits
// - Stop is data rising while clock high
// - Each further write byte updates the wiper unless locked without override
// - Further reads alternate wiper and status bytes
// - Status 00 ready, 10 error, 11 locked
// - Answer only the address set by pins
// - Sample data on serial clock rising edge
// - Instruction: trim, park, program, zero, override
// - Write is address, instruction, data, each acked
// - Override allows change; clearing restores fuse setting
// - Park keeps stored wiper; unpark reapplies it
`ifndef POT_DEFS_SVH
`define POT_DEFS_SVH

// Fixed upper part of the target address
`define POT_ADDR_PREFIX 5'h0B
// Wiper value after reset while no fuse is blown
`define POT_MIDSCALE 8'h80
// Bits of one byte before the acknowledge clock
`define POT_BYTE_BITS 4'h8
// Index of the last data bit in the byte count
`define POT_LAST_BIT 4'h7
// Instruction byte field positions
`define POT_IB_TRIM 7
`define POT_IB_PARK 6
`define POT_IB_PROG 5
`define POT_IB_ZERO 4
`define POT_IB_OVR 3
// Don't-care filler in the status byte
`define POT_STATUS_FILL 6'h00

`endif

/* File: pot_pkg.sv */
// Purpose: shared types of the serial target port
// Assumes: pot_defs.svh holds every number
// Notes: no module uses import; names are written pot_pkg::name
package pot_pkg;

   // Transfer phase of the byte engine
   typedef enum logic [2:0] {
      POT_IDLE   = 3'b000,
      POT_ADDR   = 3'b001,
      POT_INSTR  = 3'b010,
      POT_WRITE  = 3'b011,
      POT_READ   = 3'b100,
      POT_IGNORE = 3'b101
   } pot_phase_t;

   // Bit handed from the serial clock domain: toggle marks a new bit
   typedef struct packed {
      logic tgl;
      logic val;
   } pot_link_t;

   // State of the fuse array outside this block
   typedef struct packed {
      logic blown;
      logic fault;
      logic [7:0] value;
   } pot_fuse_t;

   // Request to the fuse array
   typedef struct packed {
      logic pulse;
      logic trim;
      logic [7:0] value;
   } pot_prog_t;

   // State of the serial clock sampler
   typedef struct packed {
      logic [1:0] rst_s;
      pot_link_t link;
   } pot_smp_st_t;

   // State of the wiper store
   typedef struct packed {
      logic [7:0] vol;
      logic [7:0] wiper;
      logic park;
      logic trim;
      logic ovr;
      pot_prog_t prog;
      logic st_high;
      logic st_low;
   } pot_wip_st_t;

   // State of the byte engine
   typedef struct packed {
      logic [1:0] scl_s;
      logic [1:0] sda_s;
      logic [1:0] ad0_s;
      logic [1:0] ad1_s;
      logic [1:0] tgl_s;
      logic tgl_prev;
      logic scl_prev;
      logic sda_prev;
      pot_phase_t phase;
      logic [3:0] cnt;
      logic [7:0] shreg;
      logic [7:0] tx;
      logic rw;
      logic rd_status;
      logic ack_req;
      logic oe;
      logic [7:0] instr;
      logic instr_we;
      logic data_we;
      logic [7:0] wdata;
   } pot_main_st_t;

endpackage

/* File: pot_scl_sampler.sv */
// Purpose: samples the data pin on every rising serial clock edge
// Assumes: the serial clock may stop between frames
// Notes: each sample flips a toggle; value is held until the next edge
`timescale 1ns/100ps
`include "pot_defs.svh"
module pot_scl_sampler (
   input wire logic scl,
   input wire logic srst,
   input wire logic sda_in,
   output pot_pkg::pot_link_t link
);

   // All sampler state
   pot_pkg::pot_smp_st_t st;
   pot_pkg::pot_smp_st_t next_st;

   // Reset is brought over by two flops; toggle meaning is edge only
   always_comb begin
      next_st = st;
      next_st.rst_s = {st.rst_s[0], srst};
      if (st.rst_s[1]) begin
         next_st.link.tgl = 1'b0;
         next_st.link.val = 1'b1;
      end else begin
         // One sample per rising edge, held stable for the other domain
         next_st.link.tgl = ~st.link.tgl;
         next_st.link.val = sda_in;
      end
   end

   // Registered on the serial clock only
   always_ff @(posedge scl) begin
      st <= next_st;
   end

   assign link = st.link;

endmodule // pot_scl_sampler

/* File: pot_wiper_store.sv */
// Purpose: holds wiper, instruction flags and fuse status view
// Assumes: fuse array signals are on clk
// Notes: fuse electrical programming is outside; this issues one request pulse
`timescale 1ns/100ps
`include "pot_defs.svh"
module pot_wiper_store (
   input wire logic clk,
   input wire logic srst,
   input wire logic instr_we,
   input wire logic [7:0] instr,
   input wire logic data_we,
   input wire logic [7:0] wdata,
   input pot_pkg::pot_fuse_t fuse,
   output logic [7:0] wiper_setting,
   output logic wiper_park_bit,
   output logic second_trim_select,
   output pot_pkg::pot_prog_t prog,
   output logic otp_status_high,
   output logic otp_status_low
);

   // All store state
   pot_pkg::pot_wip_st_t st;
   pot_pkg::pot_wip_st_t next_st;
   // Volatile register may be written
   logic writable;

   // Instruction flags, wiper writes and fuse requests
   always_comb begin
      next_st = st;
      next_st.prog.pulse = 1'b0;
      // Once locked, only override lets the wiper move
      writable = ~fuse.blown | st.ovr;
      if (instr_we) begin
         // Park only changes the flag, never the stored value
         next_st.park = instr[`POT_IB_PARK];
         next_st.trim = instr[`POT_IB_TRIM];
         next_st.ovr = instr[`POT_IB_OVR];
      end
      if (data_we) begin
         if (writable) begin
            next_st.vol = wdata;
         end
         // A faulty array is never retried
         if (instr[`POT_IB_PROG] && ~fuse.fault) begin
            next_st.prog.pulse = 1'b1;
            next_st.prog.trim = st.trim;
            next_st.prog.value = wdata;
         end
      end
      // Locked without override shows the fuse value again
      next_st.wiper = (fuse.blown && ~st.ovr) ? fuse.value : st.vol;
      // Status pair: ready, error or locked
      next_st.st_high = fuse.blown;
      next_st.st_low = fuse.blown & ~fuse.fault;
      if (srst) begin
         next_st = '0;
         next_st.vol = `POT_MIDSCALE;
         next_st.wiper = `POT_MIDSCALE;
      end
   end

   // Single state register
   always_ff @(posedge clk) begin
      st <= next_st;
   end

   assign wiper_setting = st.wiper;
   assign wiper_park_bit = st.park;
   assign second_trim_select = st.trim;
   assign prog = st.prog;
   assign otp_status_high = st.st_high;
   assign otp_status_low = st.st_low;

endmodule // pot_wiper_store

/* File: pot_serial_target.sv */
// Purpose: two-wire target port of the programmable potentiometer
// Assumes: clk far faster than the serial clock; data pin is open drain
// Notes: bits are taken on the serial clock, framing and driving on clk
`timescale 1ns/100ps
`include "pot_defs.svh"
module pot_serial_target (
   input wire logic clk,
   input wire logic srst,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic addr_select_bit0,
   input wire logic addr_select_bit1,
   input pot_pkg::pot_fuse_t fuse,
   output logic [7:0] wiper_setting,
   output logic wiper_park_bit,
   output logic second_trim_select,
   output pot_pkg::pot_prog_t prog,
   output logic otp_status_high,
   output logic otp_status_low
);

   // All engine state
   pot_pkg::pot_main_st_t st;
   pot_pkg::pot_main_st_t next_st;
   // Sample handed over from the serial clock domain
   pot_pkg::pot_link_t link;
   // Derived bus events
   logic scl_hi;
   logic start_ev;
   logic stop_ev;
   logic scl_fall;
   logic bit_ev;
   logic bit_val;
   // Completed byte and its own address
   logic [7:0] byte_in;
   logic [6:0] own_addr;

   // Bit capture runs on the serial clock itself
   pot_scl_sampler u_sampler (
      .scl(scl),
      .srst(srst),
      .sda_in(sda_in),
      .link(link)
   );

   // Wiper, flags and status kept on clk
   pot_wiper_store u_store (
      .clk(clk),
      .srst(srst),
      .instr_we(st.instr_we),
      .instr(st.instr),
      .data_we(st.data_we),
      .wdata(st.wdata),
      .fuse(fuse),
      .wiper_setting(wiper_setting),
      .wiper_park_bit(wiper_park_bit),
      .second_trim_select(second_trim_select),
      .prog(prog),
      .otp_status_high(otp_status_high),
      .otp_status_low(otp_status_low)
   );

   // Framing from synchronised pins; all but the held sample value come from second flops
   always_comb begin
      scl_hi = st.scl_s[1] & st.scl_prev;
      // Falling data with clock high opens a frame
      start_ev = scl_hi & st.sda_prev & ~st.sda_s[1];
      // Rising data with clock high closes it
      stop_ev = scl_hi & ~st.sda_prev & st.sda_s[1];
      // Driving changes only just after the clock falls
      scl_fall = st.scl_prev & ~st.scl_s[1];
      // New toggle means one more rising-edge sample
      bit_ev = st.tgl_s[1] ^ st.tgl_prev;
      // Value was set with the toggle and is stable by now
      bit_val = link.val;
      byte_in = {st.shreg[6:0], bit_val};
      own_addr = {`POT_ADDR_PREFIX, st.ad1_s[1], st.ad0_s[1]};
   end

   // Byte engine
   always_comb begin
      next_st = st;
      next_st.instr_we = 1'b0;
      next_st.data_we = 1'b0;
      // Two flops on every pin and on the toggle
      next_st.scl_s = {st.scl_s[0], scl};
      next_st.sda_s = {st.sda_s[0], sda_in};
      next_st.ad0_s = {st.ad0_s[0], addr_select_bit0};
      next_st.ad1_s = {st.ad1_s[0], addr_select_bit1};
      next_st.tgl_s = {st.tgl_s[0], link.tgl};
      next_st.tgl_prev = st.tgl_s[1];
      next_st.scl_prev = st.scl_s[1];
      next_st.sda_prev = st.sda_s[1];
      if (start_ev) begin
         // Abandon any byte in flight and listen for an address
         next_st.phase = pot_pkg::POT_ADDR;
         next_st.cnt = 4'h0;
         next_st.ack_req = 1'b0;
         next_st.oe = 1'b0;
      end else if (stop_ev) begin
         // End of transfer; next one must begin with a start
         next_st.phase = pot_pkg::POT_IDLE;
         next_st.cnt = 4'h0;
         next_st.ack_req = 1'b0;
         next_st.oe = 1'b0;
      end else begin
         // Sampled bit while a transfer is addressed to us
         if (bit_ev && st.phase != pot_pkg::POT_IDLE && st.phase != pot_pkg::POT_IGNORE) begin
            if (st.cnt < `POT_BYTE_BITS) begin
               // Data bit, most significant first
               next_st.shreg = byte_in;
               next_st.cnt = st.cnt + 4'h1;
               next_st.tx = {st.tx[6:0], 1'b1};
               if (st.cnt == `POT_LAST_BIT) begin
                  next_st.ack_req = 1'b0;
                  case (st.phase)
                     pot_pkg::POT_ADDR: begin
                        next_st.rw = byte_in[0];
                        if (byte_in[7:1] == own_addr) begin
                           next_st.ack_req = 1'b1;
                        end else begin
                           // Not ours: stay off the line until a start
                           next_st.phase = pot_pkg::POT_IGNORE;
                        end
                     end
                     pot_pkg::POT_INSTR: begin
                        if (byte_in[`POT_IB_ZERO]) begin
                           // Reserved bit set: refuse instruction
                           next_st.phase = pot_pkg::POT_IGNORE;
                        end else begin
                           next_st.ack_req = 1'b1;
                           next_st.instr = byte_in;
                           next_st.instr_we = 1'b1;
                        end
                     end
                     pot_pkg::POT_WRITE: begin
                        // Every data byte goes to the wiper store once
                        next_st.ack_req = 1'b1;
                        next_st.wdata = byte_in;
                        next_st.data_we = 1'b1;
                     end
                     default: begin
                        // Transmitting: the master acknowledges
                        next_st.ack_req = 1'b0;
                     end
                  endcase
               end
            end else begin
               // Ninth clock: acknowledge bit
               next_st.cnt = 4'h0;
               case (st.phase)
                  pot_pkg::POT_ADDR: begin
                     if (st.rw) begin
                        // Wiper byte follows the address ack directly
                        next_st.phase = pot_pkg::POT_READ;
                        next_st.tx = wiper_setting;
                        next_st.rd_status = 1'b1;
                     end else begin
                        next_st.phase = pot_pkg::POT_INSTR;
                     end
                  end
                  pot_pkg::POT_INSTR: begin
                     // Instruction holds until a fresh transfer
                     next_st.phase = pot_pkg::POT_WRITE;
                  end
                  pot_pkg::POT_READ: begin
                     if (bit_val) begin
                        // Master said no more: wait for stop
                        next_st.phase = pot_pkg::POT_IGNORE;
                     end else if (st.rd_status) begin
                        // Status pair in the top bits
                        next_st.tx = {otp_status_high, otp_status_low, `POT_STATUS_FILL};
                        next_st.rd_status = 1'b0;
                     end else begin
                        // Further reads return the wiper again
                        next_st.tx = wiper_setting;
                        next_st.rd_status = 1'b1;
                     end
                  end
                  default: begin
                     // Write data stays in write phase until stop
                     next_st.phase = st.phase;
                  end
               endcase
            end
         end
         // Line drive is changed only after the clock has fallen
         if (scl_fall) begin
            if (st.phase == pot_pkg::POT_IDLE || st.phase == pot_pkg::POT_IGNORE) begin
               next_st.oe = 1'b0;
            end else if (st.cnt == `POT_BYTE_BITS) begin
               // Pull low for our acknowledge; release when reading
               next_st.oe = st.ack_req;
            end else if (st.phase == pot_pkg::POT_READ) begin
               // Low for a zero, released for a one
               next_st.oe = ~st.tx[7];
            end else begin
               next_st.oe = 1'b0;
            end
         end
      end
      if (srst) begin
         next_st = '0;
         next_st.phase = pot_pkg::POT_IDLE;
      end
   end

   // Single state register on clk
   always_ff @(posedge clk) begin
      st <= next_st;
   end

   // Open drain: only ever drives low
   assign sda_out = 1'b0;
   assign sda_oe = st.oe;

endmodule // pot_serial_target

/* File: pot_serial_target_sva.sv */
// Purpose: pin-level checks of the serial target port
// Assumes: each serial clock phase lasts many clk cycles
// Notes: phase age counters stand in for long repetitions
`timescale 1ns/100ps
module pot_serial_target_sva (
   input wire logic clk,
   input wire logic srst,
   input wire logic scl,
   input wire logic sda_in,
   input wire logic sda_oe,
   input pot_pkg::pot_fuse_t fuse,
   input wire logic [7:0] wiper_setting,
   input pot_pkg::pot_prog_t prog,
   input wire logic otp_status_high,
   input wire logic otp_status_low
);
   logic [3:0] lo_cnt; // Cycles since clock fell
   logic [3:0] hi_cnt; // Cycles since clock rose
   pot_pkg::pot_fuse_t fuse_q1; // Fuse one cycle old
   pot_pkg::pot_fuse_t fuse_q2; // Fuse two cycles old
   // Counters saturate, so idle bus time is harmless
   always_ff @(posedge clk) begin
      lo_cnt <= scl ? 4'h0 : ((lo_cnt == 4'hF) ? lo_cnt : lo_cnt + 4'h1);
      hi_cnt <= !scl ? 4'h0 : ((hi_cnt == 4'hF) ? hi_cnt : hi_cnt + 4'h1);
      fuse_q1 <= fuse;
      fuse_q2 <= fuse_q1;
   end
   property p_oe_at_fall;
      @(posedge clk) disable iff (srst) $changed(sda_oe) |-> !scl && lo_cnt inside {[4'h1:4'h6]};
   endproperty
   a_oe_at_fall: assert property (p_oe_at_fall) else $error("drive moved away from clock fall");
   property p_oe_stable_high;
      @(posedge clk) disable iff (srst) (hi_cnt >= 4'h6) |-> $stable(sda_oe);
   endproperty
   a_oe_stable_high: assert property (p_oe_stable_high) else $error("drive moved in clock high");
   property p_start_quiet;
      @(posedge clk) disable iff (srst) ($fell(sda_in) && scl && $past(scl)) |=> !sda_oe [*8];
   endproperty
   a_start_quiet: assert property (p_start_quiet) else $error("drive right after start");
   property p_stop_quiet;
      @(posedge clk) disable iff (srst) ($rose(sda_in) && scl && $past(scl)) |=> !sda_oe [*8];
   endproperty
   a_stop_quiet: assert property (p_stop_quiet) else $error("drive right after stop");
   property p_status_map;
      @(posedge clk) disable iff (srst) !$past(srst) |-> otp_status_high == $past(fuse.blown)
         && otp_status_low == ($past(fuse.blown) && !$past(fuse.fault));
   endproperty
   a_status_map: assert property (p_status_map) else $error("status bits wrong");
   property p_reset_wiper;
      @(posedge clk) disable iff (srst) $fell(srst) |-> wiper_setting == 8'h80 && !sda_oe;
   endproperty
   a_reset_wiper: assert property (p_reset_wiper) else $error("wiper not midscale");
   // Wiper moves only after a data bit, i.e. in clock high
   property p_wiper_on_bit;
      @(posedge clk) disable iff (srst)
         ($changed(wiper_setting) && fuse == fuse_q1 && fuse_q1 == fuse_q2) |-> scl;
   endproperty
   a_wiper_on_bit: assert property (p_wiper_on_bit) else $error("wiper moved off a bit");
   property p_prog_once;
      @(posedge clk) disable iff (srst) prog.pulse |=> !prog.pulse;
   endproperty
   a_prog_once: assert property (p_prog_once) else $error("program pulse too long");
endmodule // pot_serial_target_sva
bind pot_serial_target pot_serial_target_sva u_sva (.clk(clk), .srst(srst), .scl(scl), .sda_in(sda_in),
   .sda_oe(sda_oe), .fuse(fuse), .wiper_setting(wiper_setting), .prog(prog),
   .otp_status_high(otp_status_high), .otp_status_low(otp_status_low));

/* File: pot_master_model.sv */
// Purpose: behavioural bus master on the two-wire pins
// Assumes: data wire has a pull-up; sda_m high releases it
// Notes: 96 ns bit time keeps phases above eight clk cycles
`timescale 1ns/100ps
module pot_master_model (
   output logic scl,
   output logic sda_m,
   input wire logic sda_in
);
   localparam int Q = 24; // Quarter bit time in ns
   // Clock idles high and stands still outside frames
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   // Short pulses with data high, for the sampler reset
   task automatic pulses(input int n);
      repeat (n) begin
         #4 scl = 1'b0;
         #4 scl = 1'b1;
      end
   endtask
   task automatic start;
      sda_m = 1'b1;
      #Q scl = 1'b1;
      #Q sda_m = 1'b0;
      #Q scl = 1'b0;
      #Q;
   endtask
   // Data set in clock low, held over the high phase
   task automatic put_bit(input logic b);
      sda_m = b;
      #Q scl = 1'b1;
      #(2*Q) scl = 1'b0;
      #Q;
   endtask
   task automatic get_bit(output logic b);
      sda_m = 1'b1;
      #Q scl = 1'b1;
      #Q b = sda_in;
      #Q scl = 1'b0;
      #Q;
   endtask
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--) put_bit(d[i]);
      get_bit(ack);
   endtask
   task automatic rd_byte(output logic [7:0] d, input logic nack);
      for (int i = 7; i >= 0; i--) get_bit(d[i]);
      put_bit(nack);
   endtask
   // Low first so the rise in clock high forms a stop
   task automatic stop;
      sda_m = 1'b0;
      #Q scl = 1'b1;
      #Q sda_m = 1'b1;
      #(2*Q);
   endtask
endmodule // pot_master_model

/* File: pot_serial_target_tb.sv */
// Purpose: self-checking bench of the serial target port
// Assumes: master model owns the serial pins
// Notes: fuse value equals the last written wiper on purpose
`timescale 1ns/100ps
module pot_serial_target_tb;
   logic clk; // System clock
   logic srst; // Synchronous reset
   logic scl; // Serial clock
   logic sda_m; // Master drive, high releases
   logic sda_out; // Device drive value
   logic sda_oe; // Device pulls low
   logic sda_in; // Wire level
   logic addr_select_bit0; // Address pins
   logic addr_select_bit1;
   pot_pkg::pot_fuse_t fuse; // Fuse array view
   pot_pkg::pot_prog_t prog; // Program request
   logic [7:0] wiper_setting;
   logic wiper_park_bit;
   logic second_trim_select;
   logic otp_status_high;
   logic otp_status_low;
   logic ack; // Last acknowledge
   logic [7:0] rd; // Last byte read
   logic got_pulse; // Program pulse seen
   logic [7:0] prog_val; // Value it carried
   int mismatches;
   int checked;
   // Pull-up; either party may pull low
   assign sda_in = sda_m & ~(sda_oe & ~sda_out);
   pot_master_model m (.scl(scl), .sda_m(sda_m), .sda_in(sda_in));
   pot_serial_target dut (.clk(clk), .srst(srst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
      .sda_oe(sda_oe), .addr_select_bit0(addr_select_bit0), .addr_select_bit1(addr_select_bit1),
      .fuse(fuse), .wiper_setting(wiper_setting), .wiper_park_bit(wiper_park_bit),
      .second_trim_select(second_trim_select), .prog(prog), .otp_status_high(otp_status_high),
      .otp_status_low(otp_status_low));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Catch the one-cycle program request
   always @(posedge clk) begin
      if (prog.pulse === 1'b1) begin
         got_pulse <= 1'b1;
         prog_val <= prog.value;
      end
   end
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic print_verdict;
      if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   function automatic logic [7:0] abyte(input logic rw);
      return {5'h0B, addr_select_bit1, addr_select_bit0, rw};
   endfunction
   task automatic wr(input logic [7:0] d, input logic exp_ack);
      m.wr_byte(d, ack);
      check("ack", {7'h00, exp_ack}, {7'h00, ack});
   endtask
   task automatic open(input logic rw);
      m.start;
      wr(abyte(rw), 1'b0);
   endtask
   // Pins change just after an edge, then settle
   task automatic set_pins(input logic b, input logic f, input logic [1:0] ad);
      @(posedge clk);
      #1 fuse = '{blown: b, fault: f, value: 8'h3C};
      {addr_select_bit1, addr_select_bit0} = ad;
      repeat (4) @(posedge clk);
      // Leave the edge so master timing stays off the clock
      #1;
   endtask
   task automatic sc_reset;
      check("wiper", 8'h80, wiper_setting);
      check("drive", 8'h00, {7'h00, sda_oe});
      check("drive value", 8'h00, {7'h00, sda_out});
      check("park", 8'h00, {7'h00, wiper_park_bit});
   endtask
   task automatic sc_write;
      open(1'b0);
      wr(8'h00, 1'b0);
      wr(8'hA5, 1'b0);
      check("wiper", 8'hA5, wiper_setting);
      wr(8'h3C, 1'b0);
      check("wiper", 8'h3C, wiper_setting);
      m.stop;
   endtask
   // Ready, error and locked status codes in turn
   task automatic sc_read;
      logic [1:0] bf [3] = '{2'b00, 2'b11, 2'b10};
      for (int i = 0; i < 3; i++) begin
         set_pins(bf[i][1], bf[i][0], 2'b10);
         open(1'b1);
         m.rd_byte(rd, 1'b0);
         check("read wiper", 8'h3C, rd);
         m.rd_byte(rd, 1'b0);
         check("status", {bf[i][1], bf[i][1] & ~bf[i][0], 6'h00}, {rd[7:6], 6'h00});
         m.rd_byte(rd, 1'b1);
         check("reread wiper", 8'h3C, rd);
         m.stop;
      end
      set_pins(1'b0, 1'b0, 2'b10);
   endtask
   task automatic sc_foreign;
      m.start;
      m.wr_byte({5'h0B, ~addr_select_bit1, addr_select_bit0, 1'b0}, ack);
      check("foreign ack", 8'h01, {7'h00, ack});
      wr(8'h00, 1'b1);
      wr(8'h11, 1'b1);
      m.stop;
      check("wiper", 8'h3C, wiper_setting);
   endtask
   // Start in mid-byte, then park and trim, then unpark
   task automatic sc_park;
      open(1'b0);
      repeat (3) m.put_bit(1'b1);
      open(1'b0);
      wr(8'hC0, 1'b0);
      check("park", 8'h01, {7'h00, wiper_park_bit});
      check("trim", 8'h01, {7'h00, second_trim_select});
      wr(8'h5A, 1'b0);
      m.stop;
      open(1'b0);
      wr(8'h00, 1'b0);
      m.stop;
      check("park", 8'h00, {7'h00, wiper_park_bit});
      check("wiper", 8'h5A, wiper_setting);
   endtask
   task automatic sc_reserved;
      open(1'b0);
      wr(8'h10, 1'b1);
      wr(8'h22, 1'b1);
      m.stop;
      check("wiper", 8'h5A, wiper_setting);
   endtask
   task automatic sc_program;
      set_pins(1'b0, 1'b0, 2'b01);
      open(1'b0);
      wr(8'h20, 1'b0);
      wr(8'h77, 1'b0);
      m.stop;
      check("prog pulse", 8'h01, {7'h00, got_pulse});
      check("prog value", 8'h77, prog_val);
   endtask
   // Locked array: writes held off until override; clearing it restores
   task automatic sc_override;
      set_pins(1'b1, 1'b0, 2'b01);
      check("wiper", 8'h3C, wiper_setting);
      open(1'b0);
      wr(8'h00, 1'b0);
      wr(8'h11, 1'b0);
      m.stop;
      check("wiper", 8'h3C, wiper_setting);
      open(1'b0);
      wr(8'h08, 1'b0);
      wr(8'h44, 1'b0);
      m.stop;
      check("wiper", 8'h44, wiper_setting);
      open(1'b0);
      wr(8'h00, 1'b0);
      m.stop;
      check("wiper", 8'h3C, wiper_setting);
   endtask
   initial begin
      srst = 1'b1;
      fuse = '0;
      addr_select_bit1 = 1'b1;
      addr_select_bit0 = 1'b0;
      mismatches = 0;
      checked = 0;
      got_pulse = 1'b0;
      prog_val = 8'h00;
      // Sampler takes reset on serial clock edges: three to load it
      fork
         m.pulses(3);
         repeat (16) @(posedge clk);
      join
      #1 srst = 1'b0;
      // Two more edges carry the release over, else first bits are lost
      m.pulses(2);
      repeat (4) @(posedge clk);
      #1;
      sc_reset;
      sc_write;
      sc_read;
      sc_foreign;
      sc_park;
      sc_reserved;
      sc_program;
      sc_override;
      print_verdict;
   end
   // Whole run needs about 36 us
   initial begin
      #200000;
      mismatches++;
      print_verdict;
   end
endmodule // pot_serial_target_tb
